// [rtl/acw_map.svh]
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: 8-bit register port, byte offsets
// Notes: Definitions only
`ifndef ACW_MAP_SVH
`define ACW_MAP_SVH

// Register offsets
`define ACW_ADDR_CPT 8'hba
`define ACW_ADDR_CCF 8'hbb
`define ACW_ADDR_CFG0 8'hbc
`define ACW_ADDR_CFG1 8'hbd
`define ACW_ADDR_DATL 8'hbe
`define ACW_ADDR_DATH 8'hbf
`define ACW_ADDR_GTL 8'hc4
`define ACW_ADDR_GTH 8'hc5
`define ACW_ADDR_LTL 8'hc6
`define ACW_ADDR_LTH 8'hc7
`define ACW_ADDR_CTL 8'he8

// Reset values
`define ACW_CPT_RESET 8'hd7
`define ACW_GT_RESET 8'hff
`define ACW_LT_RESET 8'h00
`define ACW_OFS_ZERO 14'h2000
`define ACW_GAIN_RESET 13'h0000

// Field positions
`define ACW_CPT_POINTER_AUTO_INCREMENT 7
`define ACW_CPT_SEL 6
`define ACW_CFG_LCAL 0
`define ACW_CFG_OCAL 1
`define ACW_CFG_GCAL 2
`define ACW_CFG_SCAL 3
`define ACW_CTL_DIFF 0
`define ACW_CTL_WINT 5

// Coefficient locations
`define ACW_LOC_LIN_LAST 6'h12
`define ACW_LOC_OFS_LO 6'h13
`define ACW_LOC_OFS_HI 6'h14
`define ACW_LOC_GAIN_LO 6'h15
`define ACW_LOC_GAIN_HI 6'h16

// Calibration run length in clocks
`define ACW_CAL_CYCLES 64

`endif

// [rtl/acw_pkg.sv]
// Purpose: Shared types of the calibration and window block
// Assumes: Nothing
// Notes: Offsets live in acw_map.svh
package acw_pkg;
   // Calibration run in progress
   typedef enum logic [1:0] {
      ACW_IDLE = 2'b00,
      ACW_LIN = 2'b01,
      ACW_OFS = 2'b10,
      ACW_GAIN = 2'b11
   } acw_cal_type;
endpackage : acw_pkg

// [rtl/acw_coef_ram.sv]
// Purpose: Linearity coefficient store with registered read data
// Assumes: Write and read never in the same cycle
// Notes: The read register loads altData when no memory read is asked
`timescale 1ns/100ps
module acw_coef_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Write port
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read port
   input wire logic rdEn,
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   input wire logic [WIDTH-1:0] altData,
   output logic [WIDTH-1:0] q
);
   import acw_pkg::*;

   if (DEPTH < 2 || WIDTH < 1) begin : gBad
      $error("acw_coef_ram: DEPTH must be at least 2 and WIDTH at least 1");
   end

   logic [WIDTH-1:0] mem [DEPTH]; // Coefficient words, no reset
   logic [WIDTH-1:0] next_q; // Next read data

   ////////////////////////////////////////////////////////////////
   // Read data select
   always_comb begin
      next_q = rdEn ? mem[rdAddr] : altData;
   end

   // Memory write
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Read register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule : acw_coef_ram

// [rtl/acw_window_cmp.sv]
// Purpose: Window comparison of one conversion result
// Assumes: sample is a one-cycle end-of-conversion pulse
// Notes: hit is a one-cycle pulse, one clock after sample
`timescale 1ns/100ps
module acw_window_cmp #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Sample and limits
   input wire logic sample,
   input wire logic [W-1:0] data,
   input wire logic [W-1:0] upper,
   input wire logic [W-1:0] lower,
   input wire logic twos,
   // Result
   output logic hit
);
   import acw_pkg::*;

   if (W < 2) begin : gBad
      $error("acw_window_cmp: W must be at least 2");
   end

   logic [W-1:0] flip; // Sign flip for two's complement order
   logic [W-1:0] d, g, l; // Values in unsigned order
   logic next_hit; // Next hit pulse

   ////////////////////////////////////////////////////////////////
   // Compare once per sample
   always_comb begin
      flip = {twos, {(W-1){1'b0}}}; // RULE19
      d = data ^ flip;
      g = upper ^ flip;
      l = lower ^ flip;
      next_hit = 1'b0;
      if (sample) begin // RULE19
         if (g < l) begin
            // Limits bound a window: flag inside it
            next_hit = (d > g) && (d < l); // RULE16
         end else begin
            // Limits crossed: flag outside them
            next_hit = (d > g) || (d < l); // RULE16
         end
      end
   end

   // Hit register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hit <= 1'b0;
      end else begin
         hit <= next_hit;
      end
   end
endmodule : acw_window_cmp

// [rtl/acw_cal_window.sv]
// Purpose: Calibration sequencer, coefficient access and window detector
// Assumes: Register port strobes one cycle long, never both at once
// Notes: Read data stand the cycle after the read strobe only
//
// Function
// RULE1: Linearity start bit runs, hardware clears it
// RULE2: Source bit picks internal or external voltages
// RULE3: Software runs offset before gain calibration
// RULE4: Offset start bit runs, hardware clears it
// RULE5: Gain start bit runs, hardware clears it
// RULE6: Offset coefficient drives ground-reference input correction
// RULE7: Offset 0x2000 zero, 0x3fff minus, 0x0000 plus
// RULE8: Gain coefficient drives reference path slope
// RULE9: Auto-increment advances index per access
// RULE10: Select bit picks converter for coefficients
// RULE11: Six-bit index picks coefficient location
// RULE12: Window hit sets flag, readable for polling
// RULE13: Limits held as separate high, low bytes
// RULE14: Single-ended compares first converter result
// RULE15: Differential compares combined first data word
// RULE16: Limit order picks inside or outside
// RULE17: Each converter has own start bits
// RULE18: Locations for linearity, offset, gain bytes
// RULE19: Compare at conversion end, signed if differential
// RULE20: Calibration pending blocks conversion starts
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "acw_map.svh"
module acw_cal_window #(
   parameter int CAL_CYCLES = `ACW_CAL_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // Conversion control
   input wire logic [1:0] convStartReq,
   output logic [1:0] convStart,
   input wire logic endOfConv0,
   input wire logic [15:0] conv0Data,
   // Calibration engine
   input wire logic [13:0] calCoefIn [2],
   output acw_pkg::acw_cal_type calKind [2],
   output logic [1:0] calSourceExternal,
   output logic [14:0] offsetCorrection [2],
   output logic [12:0] gainCoef [2],
   // Window detector
   output logic windowHitFlag
);
   import acw_pkg::*;

   // Run counter width
   localparam int CW = $clog2(CAL_CYCLES + 1);

   if (CAL_CYCLES < 1) begin : gBad
      $error("acw_cal_window: CAL_CYCLES must be at least 1");
   end

   ////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] ptr, next_ptr; // Calibration pointer
   logic [7:0] gtl, gth, ltl, lth; // Limit bytes
   logic [7:0] next_gtl, next_gth, next_ltl, next_lth;
   logic diffMode, next_diffMode; // Differential operation
   logic flag, next_flag; // Window hit flag
   logic [15:0] data0, next_data0; // First converter data word
   logic winHit; // Comparator pulse
   logic wrCcf, rdCcf; // Coefficient port access
   logic [1:0] wrCfg; // Configuration writes
   logic [5:0] idx; // Coefficient index
   logic sel; // Converter select
   logic ramWr, ramRd; // Linearity store access
   logic [7:0] alt; // Non-memory read data
   logic [3:0] cfgArr [2]; // Configuration per converter
   logic [13:0] ofsArr [2]; // Offset coefficient per converter
   logic [12:0] gainArr [2]; // Gain coefficient per converter

   // Pointer fields
   assign idx = ptr[5:0];
   assign sel = ptr[`ACW_CPT_SEL];
   assign windowHitFlag = flag;

   ////////////////////////////////////////////////////////////////
   // Access decode
   always_comb begin
      wrCcf = regWrite && (regAddr == `ACW_ADDR_CCF);
      rdCcf = regRead && (regAddr == `ACW_ADDR_CCF);
      wrCfg[0] = regWrite && (regAddr == `ACW_ADDR_CFG0); // RULE17
      wrCfg[1] = regWrite && (regAddr == `ACW_ADDR_CFG1); // RULE17
      // Offset and gain live in flops
      ramWr = wrCcf && (idx <= `ACW_LOC_LIN_LAST); // RULE18
      ramRd = rdCcf && (idx <= `ACW_LOC_LIN_LAST); // RULE18
   end

   ////////////////////////////////////////////////////////////////
   // Pointer, limits, control and data word
   // Hardware events are applied last so they win
   always_comb begin
      next_ptr = ptr;
      next_gtl = gtl;
      next_gth = gth;
      next_ltl = ltl;
      next_lth = lth;
      next_diffMode = diffMode;
      next_flag = flag;
      next_data0 = data0;
      if (regWrite) begin
         case (regAddr)
            `ACW_ADDR_CPT: next_ptr = regWrData; // RULE11
            `ACW_ADDR_GTL: next_gtl = regWrData; // RULE13
            `ACW_ADDR_GTH: next_gth = regWrData; // RULE13
            `ACW_ADDR_LTL: next_ltl = regWrData; // RULE13
            `ACW_ADDR_LTH: next_lth = regWrData; // RULE13
            `ACW_ADDR_CTL: begin
               // Software may clear or set the flag
               next_diffMode = regWrData[`ACW_CTL_DIFF];
               next_flag = regWrData[`ACW_CTL_WINT];
            end
            default: begin
               // Other writes leave these registers alone
            end
         endcase
      end
      // Index advances after each coefficient access when the auto-increment bit is set
      if ((wrCcf || rdCcf) && ptr[`ACW_CPT_POINTER_AUTO_INCREMENT]) begin
         next_ptr[5:0] = idx + 6'h01; // RULE9
      end
      // Result lands in the first data word; combined word when differential
      if (endOfConv0) begin
         next_data0 = conv0Data; // RULE14 RULE15
      end
      // A hit in the clearing cycle still sets the flag
      if (winHit) begin
         next_flag = 1'b1; // RULE12
      end
   end

   // Registers of the common group
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr <= `ACW_CPT_RESET;
         gtl <= `ACW_GT_RESET;
         gth <= `ACW_GT_RESET;
         ltl <= `ACW_LT_RESET;
         lth <= `ACW_LT_RESET;
         diffMode <= 1'b0;
         flag <= 1'b0;
         data0 <= '0;
      end else begin
         ptr <= next_ptr;
         gtl <= next_gtl;
         gth <= next_gth;
         ltl <= next_ltl;
         lth <= next_lth;
         diffMode <= next_diffMode;
         flag <= next_flag;
         data0 <= next_data0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Window comparator on the first converter
   // Raw result feeds it; data word loads alongside
   acw_window_cmp #(
      .W(16)
   ) uWin (
      .clk(clk),
      .nrst(nrst),
      .sample(endOfConv0), // RULE19
      .data(conv0Data), // RULE14 RULE15
      .upper({gth, gtl}),
      .lower({lth, ltl}),
      .twos(diffMode), // RULE19
      .hit(winHit)
   );

   ////////////////////////////////////////////////////////////////
   // Calibration sequencer per converter
   // Pending runs queue, one idle cycle apart
   for (genvar n = 0; n < 2; n++) begin : gConv
      logic [3:0] cfg, next_cfg; // Start and source bits
      logic [CW-1:0] cnt, next_cnt; // Run cycle counter
      acw_cal_type kind, next_kind; // Active run
      logic [13:0] ofs, next_ofs; // Offset coefficient
      logic [12:0] gain, next_gain; // Gain coefficient
      logic [14:0] corr, next_corr; // Decoded offset correction
      logic start, next_start; // Gated conversion start
      logic mine; // Coefficient port aims here

      // Next run state
      always_comb begin
         next_cfg = cfg;
         next_cnt = cnt;
         next_kind = kind;
         next_ofs = ofs;
         next_gain = gain;
         mine = (sel == 1'(n)); // RULE10
         case (kind)
            ACW_IDLE: begin
               // Pick pending runs, offset before gain
               next_cnt = '0;
               if (cfg[`ACW_CFG_LCAL]) begin
                  next_kind = ACW_LIN; // RULE1
               end else if (cfg[`ACW_CFG_OCAL]) begin
                  next_kind = ACW_OFS; // RULE4 RULE3
               end else if (cfg[`ACW_CFG_GCAL]) begin
                  next_kind = ACW_GAIN; // RULE5
               end
            end
            default: begin
               if (cnt == CW'(CAL_CYCLES - 1)) begin
                  // Run done: clear its start bit; offset and gain runs keep their result
                  next_kind = ACW_IDLE;
                  case (kind)
                     ACW_LIN: next_cfg[`ACW_CFG_LCAL] = 1'b0; // RULE1
                     ACW_OFS: begin
                        next_cfg[`ACW_CFG_OCAL] = 1'b0; // RULE4
                        next_ofs = calCoefIn[n];
                     end
                     ACW_GAIN: begin
                        next_cfg[`ACW_CFG_GCAL] = 1'b0; // RULE5
                        next_gain = calCoefIn[n][12:0];
                     end
                     default: begin
                        // Idle never reaches here
                     end
                  endcase
               end else begin
                  next_cnt = cnt + 1'b1;
               end
            end
         endcase
         // Software may set start bits but not abort a run
         if (wrCfg[n]) begin
            next_cfg[`ACW_CFG_SCAL] = regWrData[`ACW_CFG_SCAL]; // RULE2
            next_cfg[2:0] = next_cfg[2:0] | regWrData[2:0]; // RULE17
         end
         // Direct coefficient writes
         if (wrCcf && mine) begin
            case (idx)
               `ACW_LOC_OFS_LO: next_ofs[7:0] = regWrData; // RULE18
               `ACW_LOC_OFS_HI: next_ofs[13:8] = regWrData[5:0]; // RULE18
               `ACW_LOC_GAIN_LO: next_gain[7:0] = regWrData; // RULE18
               `ACW_LOC_GAIN_HI: next_gain[12:8] = regWrData[4:0]; // RULE18
               default: begin
                  // Linearity words go to the store
               end
            endcase
         end
         // Correction relative to the mid-scale zero code
         next_corr = {1'b0, `ACW_OFS_ZERO} - {1'b0, next_ofs}; // RULE7 RULE6
         // No conversion starts while any start bit is pending
         next_start = convStartReq[n] && (cfg[2:0] == 3'h0); // RULE20
      end

      // Run state registers
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            cfg <= '0;
            cnt <= '0;
            kind <= ACW_IDLE;
            ofs <= `ACW_OFS_ZERO;
            gain <= `ACW_GAIN_RESET;
            corr <= '0;
            start <= 1'b0;
         end else begin
            cfg <= next_cfg;
            cnt <= next_cnt;
            kind <= next_kind;
            ofs <= next_ofs;
            gain <= next_gain;
            corr <= next_corr;
            start <= next_start;
         end
      end

      // Results to the read mux and ports
      assign cfgArr[n] = cfg;
      assign ofsArr[n] = ofs;
      assign gainArr[n] = gain;
      assign calKind[n] = kind;
      assign calSourceExternal[n] = cfg[`ACW_CFG_SCAL]; // RULE2
      assign offsetCorrection[n] = corr; // RULE6
      assign gainCoef[n] = gain; // RULE8
      assign convStart[n] = start;
   end

   ////////////////////////////////////////////////////////////////
   // Read data select for registers outside the store
   // Zero unless a read is asked
   always_comb begin
      alt = 8'h00;
      if (regRead) begin
         case (regAddr)
            `ACW_ADDR_CPT: alt = ptr;
            `ACW_ADDR_CFG0: alt = {4'h0, cfgArr[0]};
            `ACW_ADDR_CFG1: alt = {4'h0, cfgArr[1]};
            `ACW_ADDR_DATL: alt = data0[7:0];
            `ACW_ADDR_DATH: alt = data0[15:8];
            `ACW_ADDR_GTL: alt = gtl;
            `ACW_ADDR_GTH: alt = gth;
            `ACW_ADDR_LTL: alt = ltl;
            `ACW_ADDR_LTH: alt = lth;
            `ACW_ADDR_CTL: begin
               alt[`ACW_CTL_DIFF] = diffMode;
               alt[`ACW_CTL_WINT] = flag; // RULE12
            end
            `ACW_ADDR_CCF: begin
               case (idx)
                  `ACW_LOC_OFS_LO: alt = ofsArr[sel][7:0]; // RULE10
                  `ACW_LOC_OFS_HI: alt = {2'h0, ofsArr[sel][13:8]};
                  `ACW_LOC_GAIN_LO: alt = gainArr[sel][7:0];
                  `ACW_LOC_GAIN_HI: alt = {3'h0, gainArr[sel][12:8]};
                  default: alt = 8'h00;
               endcase
            end
            default: alt = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Linearity store; its read register is the read data output
   // Select bit is the top address bit
   acw_coef_ram #(
      .WIDTH(8),
      .DEPTH(64)
   ) uRam (
      .clk(clk),
      .nrst(nrst),
      .wrEn(ramWr), // RULE11
      .wrAddr({sel, idx[4:0]}), // RULE10
      .wrData(regWrData),
      .rdEn(ramRd), // RULE11
      .rdAddr({sel, idx[4:0]}), // RULE10
      .altData(alt),
      .q(regRdData)
   );
endmodule : acw_cal_window

// [bench/acw_cal_window_checker.sv]
// Purpose: Port assertions for the calibration and window block
// Assumes: calCoefIn holds steady while a run finishes
// Notes: Bound into every acw_cal_window instance
`timescale 1ns/100ps
`include "acw_map.svh"
module acw_cal_window_checker #(
   parameter int CAL_CYCLES = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   // Conversion
   input wire logic [1:0] convStartReq,
   input wire logic [1:0] convStart,
   input wire logic endOfConv0,
   // Calibration
   input wire logic [13:0] calCoefIn [2],
   input acw_pkg::acw_cal_type calKind [2],
   input wire logic [14:0] offsetCorrection [2],
   input wire logic [12:0] gainCoef [2],
   // Window
   input wire logic windowHitFlag
);
   import acw_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////
   // Cycles spent in the current converter 0 run
   int runLen;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         runLen <= 0;
      end else begin
         runLen <= (calKind[0] != ACW_IDLE) ? runLen + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////
   property p_rd_idle;
      !regRead |=> regRdData == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_gate0;
      (calKind[0] != ACW_IDLE || !convStartReq[0]) |=> !convStart[0];
   endproperty
   a_gate0: assert property (p_gate0) else $error("start 0 passed");
   property p_gate1;
      (calKind[1] != ACW_IDLE || !convStartReq[1]) |=> !convStart[1];
   endproperty
   a_gate1: assert property (p_gate1) else $error("start 1 passed");
   property p_run_len;
      (calKind[0] == ACW_IDLE && runLen != 0) |-> runLen == CAL_CYCLES;
   endproperty
   a_run_len: assert property (p_run_len) else $error("run length");
   property p_run_max;
      runLen <= CAL_CYCLES;
   endproperty
   a_run_max: assert property (p_run_max) else $error("run too long");
   property p_cal_start;
      (regWrite && regAddr == `ACW_ADDR_CFG0 && regWrData[1] && calKind[0] == ACW_IDLE)
         |-> ##[1:3] calKind[0] != ACW_IDLE;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("no run");
   property p_ofs_load;
      ($past(calKind[0]) == ACW_OFS && calKind[0] == ACW_IDLE)
         |-> ##[0:1] offsetCorrection[0] == {1'b0, `ACW_OFS_ZERO} - {1'b0, calCoefIn[0]};
   endproperty
   a_ofs_load: assert property (p_ofs_load) else $error("offset load");
   property p_gain_load;
      ($past(calKind[0]) == ACW_GAIN && calKind[0] == ACW_IDLE)
         |-> ##[0:1] gainCoef[0] == calCoefIn[0][12:0];
   endproperty
   a_gain_load: assert property (p_gain_load) else $error("gain load");
   property p_flag_cause;
      $rose(windowHitFlag) |-> ($past(endOfConv0, 2) || $past(regWrite));
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag no cause");
   property p_flag_hold;
      (windowHitFlag && !(regWrite && regAddr == `ACW_ADDR_CTL)) |=> windowHitFlag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
endmodule : acw_cal_window_checker

bind acw_cal_window acw_cal_window_checker #(.CAL_CYCLES(CAL_CYCLES)) acw_cal_window_checker_i (
   .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .convStartReq(convStartReq), .convStart(convStart), .endOfConv0(endOfConv0),
   .calCoefIn(calCoefIn), .calKind(calKind), .offsetCorrection(offsetCorrection),
   .gainCoef(gainCoef), .windowHitFlag(windowHitFlag));

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the calibration and window block
// Assumes: Short runs through CAL_CYCLES
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
`include "acw_map.svh"
module tb_top;
   import acw_pkg::*;
   localparam int RUN = 4;
   // Design inputs
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [1:0] convStartReq = 2'b00;
   logic endOfConv0 = 1'b0;
   logic [15:0] conv0Data = 16'h0000;
   logic [13:0] calCoefIn [2] = '{14'h0000, 14'h0000};
   // Design outputs
   logic [7:0] regRdData;
   logic [1:0] convStart;
   acw_cal_type calKind [2];
   logic [1:0] calSourceExternal;
   logic [14:0] offsetCorrection [2];
   logic [12:0] gainCoef [2];
   logic windowHitFlag;
   // Bench state
   logic ctlMode = 1'b0;
   int errors = 0;
   int checksDone = 0;
   ////////////////////////////////////////////////////////////////
   acw_cal_window #(.CAL_CYCLES(RUN)) acw_cal_window_i (
      .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .convStartReq(convStartReq), .convStart(convStart), .endOfConv0(endOfConv0),
      .conv0Data(conv0Data), .calCoefIn(calCoefIn), .calKind(calKind),
      .calSourceExternal(calSourceExternal), .offsetCorrection(offsetCorrection),
      .gainCoef(gainCoef), .windowHitFlag(windowHitFlag));
   // Clock of 40 ns
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d errors %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // Compare one value
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   // One-cycle register read, data checked the cycle after
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, regRdData});
   endtask : rd
   // Bounded wait for a converter to leave its run
   task automatic idle_wait(input int k);
      int n;
      n = 0;
      while (calKind[k] !== ACW_IDLE && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 100) begin
         errors++;
         end_sim();
      end
   endtask : idle_wait
   // Both window limits as byte pairs
   task automatic lim(input logic [15:0] gt, input logic [15:0] lt);
      wr(`ACW_ADDR_GTL, gt[7:0]);
      wr(`ACW_ADDR_GTH, gt[15:8]);
      wr(`ACW_ADDR_LTL, lt[7:0]);
      wr(`ACW_ADDR_LTH, lt[15:8]);
   endtask : lim
   // One conversion end, flag and data word checked, flag cleared
   task automatic conv(input logic [15:0] d, input logic h);
      @(posedge clk);
      endOfConv0 <= 1'b1;
      conv0Data <= d;
      @(posedge clk);
      endOfConv0 <= 1'b0;
      @(posedge clk);
      #1 chk("window flag", {15'h0, h}, {15'h0, windowHitFlag});
      rd(`ACW_ADDR_CTL, {2'b00, h, 4'h0, ctlMode});
      rd(`ACW_ADDR_DATL, d[7:0]);
      rd(`ACW_ADDR_DATH, d[15:8]);
      wr(`ACW_ADDR_CTL, {7'h00, ctlMode});
   endtask : conv
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(`ACW_ADDR_CPT, `ACW_CPT_RESET);
      rd(`ACW_ADDR_GTL, `ACW_GT_RESET);
      rd(`ACW_ADDR_GTH, `ACW_GT_RESET);
      rd(`ACW_ADDR_LTH, `ACW_LT_RESET);
      rd(`ACW_ADDR_CFG1, 8'h00);
      rd(8'h00, 8'h00);
      // Coefficient store, auto-increment and converter select
      wr(`ACW_ADDR_CPT, 8'h80);
      for (int i = 0; i < 3; i++) begin
         wr(`ACW_ADDR_CCF, 8'(8'h11 * (i + 1)));
      end
      rd(`ACW_ADDR_CPT, 8'h83);
      wr(`ACW_ADDR_CPT, 8'hc0);
      wr(`ACW_ADDR_CCF, 8'h5a);
      wr(`ACW_ADDR_CPT, 8'h80);
      for (int i = 0; i < 3; i++) begin
         rd(`ACW_ADDR_CCF, 8'(8'h11 * (i + 1)));
      end
      wr(`ACW_ADDR_CPT, 8'h01);
      rd(`ACW_ADDR_CCF, 8'h22);
      rd(`ACW_ADDR_CCF, 8'h22);
      rd(`ACW_ADDR_CPT, 8'h01);
      wr(`ACW_ADDR_CPT, 8'h40);
      rd(`ACW_ADDR_CCF, 8'h5a);
      // Offset places read at reset, offset and gain places rewritten
      wr(`ACW_ADDR_CPT, 8'h93);
      rd(`ACW_ADDR_CCF, 8'h00);
      rd(`ACW_ADDR_CCF, 8'h20);
      wr(`ACW_ADDR_CPT, 8'h93);
      wr(`ACW_ADDR_CCF, 8'hff);
      wr(`ACW_ADDR_CCF, 8'h3f);
      wr(`ACW_ADDR_CCF, 8'h34);
      wr(`ACW_ADDR_CCF, 8'h1f);
      repeat (2) @(posedge clk);
      #1 chk("offset corr", 16'h6001, {1'b0, offsetCorrection[0]});
      chk("gain", 16'h1f34, {3'b000, gainCoef[0]});
      // Offset run with external source, converter 0 starts held off meanwhile
      @(posedge clk);
      convStartReq <= 2'b11;
      calCoefIn[0] <= 14'h2010;
      wr(`ACW_ADDR_CFG0, 8'h0a);
      @(posedge clk);
      #1 chk("kind 0", {14'h0, ACW_OFS}, {14'h0, calKind[0]});
      chk("starts", 16'h0002, {14'h0, convStart});
      chk("source", 16'h0001, {14'h0, calSourceExternal});
      rd(`ACW_ADDR_CFG0, 8'h0a);
      idle_wait(0);
      rd(`ACW_ADDR_CFG0, 8'h08);
      chk("offset corr", 16'h7ff0, {1'b0, offsetCorrection[0]});
      chk("starts", 16'h0003, {14'h0, convStart});
      wr(`ACW_ADDR_CPT, 8'h13);
      rd(`ACW_ADDR_CCF, 8'h10);
      wr(`ACW_ADDR_CPT, 8'h53);
      rd(`ACW_ADDR_CCF, 8'h00);
      // Gain run after the offset run, internal source
      @(posedge clk);
      calCoefIn[0] <= 14'h0abc;
      wr(`ACW_ADDR_CFG0, 8'h04);
      @(posedge clk);
      #1 chk("kind 0", {14'h0, ACW_GAIN}, {14'h0, calKind[0]});
      idle_wait(0);
      rd(`ACW_ADDR_CFG0, 8'h00);
      chk("gain", 16'h0abc, {3'b000, gainCoef[0]});
      chk("source", 16'h0000, {14'h0, calSourceExternal});
      // Linearity run on the second converter alone
      wr(`ACW_ADDR_CFG1, 8'h01);
      @(posedge clk);
      #1 chk("kind 1", {14'h0, ACW_LIN}, {14'h0, calKind[1]});
      chk("kind 0", {14'h0, ACW_IDLE}, {14'h0, calKind[0]});
      chk("starts", 16'h0001, {14'h0, convStart});
      idle_wait(1);
      rd(`ACW_ADDR_CFG1, 8'h00);
      chk("offset corr 1", 16'h0000, {1'b0, offsetCorrection[1]});
      chk("gain 1", 16'h0000, {3'b000, gainCoef[1]});
      // Window inside, then outside, single-ended
      lim(16'h1000, 16'h2000);
      rd(`ACW_ADDR_GTH, 8'h10);
      conv(16'h1800, 1'b1);
      conv(16'h2000, 1'b0);
      conv(16'h0800, 1'b0);
      lim(16'h2000, 16'h1000);
      conv(16'h3000, 1'b1);
      conv(16'h0800, 1'b1);
      conv(16'h1000, 1'b0);
      // Differential data word, two's complement limits
      ctlMode <= 1'b1;
      wr(`ACW_ADDR_CTL, 8'h01);
      lim(16'hffff, 16'h1000);
      conv(16'h0000, 1'b1);
      conv(16'hfffe, 1'b0);
      conv(16'h0fff, 1'b1);
      conv(16'h1000, 1'b0);
      end_sim();
   end
endmodule : tb_top
